// File: common/cgc_pkg.sv
package cgc_pkg;
    // register byte addresses on the wishbone slave
    localparam logic [7:0] CGC_ADDR_CONTROL = 8'h00;  // global control register
    localparam logic [7:0] CGC_ADDR_STATUS  = 8'h04;  // read-only status register
    // control field positions
    localparam int CGC_BIT_SOFT_RESET   = 0;
    localparam int CGC_BIT_ENABLE       = 1;
    localparam int CGC_BIT_TEST         = 2;
    localparam int CGC_BIT_LISTEN       = 3;
    localparam int CGC_BIT_SYNC_SELECT  = 4;
    localparam int CGC_BIT_TT_MODE      = 5;
    localparam int CGC_BIT_OVL_REQUEST  = 6;
    // status field positions
    localparam int CGC_BIT_ENABLE_STATE = 2;
    localparam int CGC_BIT_OVL_ACTIVE   = 6;
    // reset values
    localparam logic [7:0] CGC_CONTROL_RESET = 8'h00;
    // enable start-up delay in clock periods
    localparam int CGC_START_CYCLES = 2;

    // protocol-engine events seen by this block
    typedef struct packed {
        logic frame_active;  // a frame is on the bus (rx or tx)
        logic rx_msg_done;   // pulse: a message was received completely
        logic ovl_start;     // pulse: overload frame transmission begins
        logic ovl_active;    // level: overload frame being sent
        logic sof;           // pulse: start-of-frame bit
        logic eof_last;      // pulse: last bit of end-of-frame
    } cgc_evt_s;

    // control outputs to the protocol engine
    typedef struct packed {
        logic engine_run;    // state machine runs
        logic clk_gate_en;   // controller input clock enable
        logic rx_enable;     // receiver active
        logic listen_mode;   // listening mode active
        logic tt_mode;       // time-triggered mode active
        logic ovl_pending;   // overload frame to be sent after next rx
        logic timer_capture; // pulse: capture tt timer
        logic ctrl_reset;    // reset of the controller core
    } cgc_ctl_s;
endpackage

// File: src/cgc_global_control.sv
// Function
// R1 - overload request sends frame after next receive
// R2 - hardware clears overload request at frame start
// R3 - tt mode bit enables time-triggered features
// R4 - sync set: capture timer at eof last
// R5 - sync clear: capture timer at start-of-frame
// R6 - sync select ignored outside tt mode
// R7 - listen bit switches listening mode
// R8 - software keeps factory test bit cleared
// R9 - enable bit enables controller and clock
// R10 - disable waits for ongoing frame end
// R11 - standby leaves object channel enables alone
// R12 - standby holds transmit output recessive
// R13 - standby: receiver off, clock stopped
// R14 - registers stay accessible while disabled
// R15 - engine starts two clocks after enable
// R16 - soft reset bit clears itself
// R17 - soft reset ored with hardware reset
// R18 - controller comes up disabled after reset
// R19 - control register reads zero after reset
// R20 - status flag reports actual enabled state
// R21 - self-clearing bits read zero once started
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
module cgc_global_control (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [7:0]      wb_dat_i,
    input  wire logic            wb_we_i,
    input  wire logic            wb_sel_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    output logic      [7:0]      wb_dat_o,
    output logic                 wb_ack_o,
    input  wire cgc_pkg::cgc_evt_s evt_i,
    input  wire logic            tx_engine_i,
    output cgc_pkg::cgc_ctl_s    ctl_o,
    output logic                 can_tx_o
);
    import cgc_pkg::*;

    typedef enum logic [1:0] {ST_OFF, ST_START, ST_RUN, ST_DRAIN} cgc_state_e;

    logic [7:0] control;            // stored control bits
    cgc_state_e state;              // enable sequencer
    logic [1:0] start_cnt;          // start-up delay counter
    logic       soft_reset;         // one-cycle soft reset pulse
    logic       ovl_armed;          // request armed by rx completion, waiting overload start
    cgc_ctl_s   next_ctl;           // combinational control outputs

    // bus decode
    wire bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire ctrl_hit   = wb_adr_i == CGC_ADDR_CONTROL;
    wire stat_hit   = wb_adr_i == CGC_ADDR_STATUS;
    wire ctrl_write = bus_req & wb_we_i & wb_sel_i & ctrl_hit;  // R14
    wire core_reset = rst_i | soft_reset;                      // R17
    wire enabled    = (state == ST_RUN) | (state == ST_DRAIN);
    wire clk_on     = state != ST_OFF;

    // status word: true enable state and overload activity
    wire [7:0] status_word = {1'b0, evt_i.ovl_active, 3'h0, enabled, 2'h0};  // R20
    // control word: self-clearing soft reset always reads zero
    wire [7:0] ctrl_word   = {control[7:1], 1'b0};                           // R21
    wire [7:0] read_word   = ctrl_hit ? ctrl_word : (stat_hit ? status_word : 8'h00);

    // wishbone: one-cycle ack, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= read_word;
        end
    end

    // soft reset pulse is generated from a write with bit 0 set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= ctrl_write & wb_dat_i[CGC_BIT_SOFT_RESET];  // R16
        end
    end

    // control register; a hw clear of the overload bit loses to a sw write
    // since sw setting it in the same cycle is a new request
    always_ff @(posedge clk_i) begin
        if (core_reset) begin
            control <= CGC_CONTROL_RESET;  // R19 R18
        end else if (ctrl_write) begin
            control <= {1'b0, wb_dat_i[6:1], 1'b0};  // R16
        end else if (evt_i.ovl_start & ovl_armed) begin
            control[CGC_BIT_OVL_REQUEST] <= 1'b0;  // R2 R21
        end
    end

    // overload arming: wait for next completed reception
    always_ff @(posedge clk_i) begin
        if (core_reset) begin
            ovl_armed <= 1'b0;
        end else if (ctrl_write & ~wb_dat_i[CGC_BIT_OVL_REQUEST]) begin
            ovl_armed <= 1'b0;
        end else if (control[CGC_BIT_OVL_REQUEST] & evt_i.rx_msg_done) begin
            ovl_armed <= 1'b1;  // R1
        end else if (evt_i.ovl_start) begin
            ovl_armed <= 1'b0;
        end
    end

    // enable sequencer: start delay and drain of an ongoing frame
    always_ff @(posedge clk_i) begin
        if (core_reset) begin
            state     <= ST_OFF;  // R18
            start_cnt <= 2'h0;
        end else begin
            unique case (state)
                ST_OFF: begin
                    start_cnt <= 2'h0;
                    if (control[CGC_BIT_ENABLE]) begin
                        state <= ST_START;  // R9
                    end
                end
                ST_START: begin
                    // clock already running, engine held for two periods
                    start_cnt <= start_cnt + 2'h1;
                    if (!control[CGC_BIT_ENABLE]) begin
                        state <= ST_OFF;
                    end else if (start_cnt == 2'(CGC_START_CYCLES - 1)) begin
                        state <= ST_RUN;  // R15
                    end
                end
                ST_RUN: begin
                    if (!control[CGC_BIT_ENABLE]) begin
                        state <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    // object channel enables are never touched here
                    if (control[CGC_BIT_ENABLE]) begin
                        state <= ST_RUN;
                    end else if (!evt_i.frame_active) begin
                        state <= ST_OFF;  // R10 R11
                    end
                end
            endcase
        end
    end

    // control outputs to the engine
    always_comb begin
        next_ctl               = '0;
        next_ctl.engine_run    = enabled;
        next_ctl.clk_gate_en   = clk_on;                      // R9 R13
        next_ctl.rx_enable     = enabled;                     // R13
        next_ctl.listen_mode   = control[CGC_BIT_LISTEN];     // R7
        next_ctl.tt_mode       = control[CGC_BIT_TT_MODE];    // R3
        next_ctl.ovl_pending   = ovl_armed;                   // R1
        next_ctl.ctrl_reset    = core_reset;                  // R17
        // capture point chosen by sync select, only in tt mode
        next_ctl.timer_capture = control[CGC_BIT_TT_MODE] & enabled &
            (control[CGC_BIT_SYNC_SELECT] ? evt_i.eof_last : evt_i.sof);  // R4 R5 R6
    end

    // registered outputs; transmit pin recessive whenever not enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_o    <= '0;
            can_tx_o <= 1'b1;
        end else begin
            ctl_o    <= next_ctl;
            can_tx_o <= enabled ? (tx_engine_i | control[CGC_BIT_LISTEN]) : 1'b1;  // R12 R7
        end
    end
endmodule

// File: testbench/cgc_global_control_assertions.sv
module cgc_global_control_assertions (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [7:0]        wb_dat_i,
    input wire logic              wb_we_i,
    input wire logic              wb_sel_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic [7:0]        wb_dat_o,
    input wire logic              wb_ack_o,
    input wire cgc_pkg::cgc_evt_s evt_i,
    input wire cgc_pkg::cgc_ctl_s ctl_o,
    input wire logic              can_tx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import cgc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // control write taken at this edge
    sequence wr_ctl;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i && wb_adr_i == CGC_ADDR_CONTROL;
    endsequence
    AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a one-cycle answer");
    AST_SRST: assert property (wr_ctl ##0 wb_dat_i[0] |-> ##[1:3] ctl_o.ctrl_reset)
        else $error("soft reset not passed on");
    AST_START: assert property (wr_ctl ##0 (wb_dat_i[1:0] == 2'b10 && !ctl_o.clk_gate_en)
        |=> !ctl_o.engine_run [*2] ##[1:3] ctl_o.engine_run) else $error("engine start delay wrong");
    AST_RD0: assert property (wb_ack_o && !wb_we_i && wb_adr_i == CGC_ADDR_CONTROL
        |-> !wb_dat_o[0] && !wb_dat_o[7]) else $error("self-clearing bit read as one");
    AST_TXREC: assert property (!ctl_o.engine_run && $past(!ctl_o.engine_run) |-> can_tx_o)
        else $error("tx dominant in standby");
    AST_LISTEN: assert property (ctl_o.listen_mode [*2] |-> can_tx_o)
        else $error("tx dominant in listen mode");
    AST_RXOFF: assert property (!ctl_o.clk_gate_en [*2] |-> !ctl_o.rx_enable)
        else $error("receiver on with clock stopped");
    // a frame in flight keeps the engine running
    AST_DRAIN: assert property (ctl_o.engine_run && evt_i.frame_active && $past(evt_i.frame_active)
        |=> ctl_o.engine_run) else $error("engine frozen mid-frame");
    AST_CAP: assert property (ctl_o.timer_capture |-> $past(evt_i.sof || evt_i.eof_last)
        && $past(ctl_o.tt_mode)) else $error("stray timer capture");
    AST_OVL: assert property (ctl_o.ovl_pending && evt_i.ovl_start |-> ##[1:2] !ctl_o.ovl_pending)
        else $error("overload request not cleared");
endmodule
bind cgc_global_control cgc_global_control_assertions chk (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
    .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .evt_i, .ctl_o, .can_tx_o);

// File: testbench/cgc_can_node.sv
module cgc_can_node (
    input  wire logic              clk_i,
    input  wire logic              go_i,
    input  wire cgc_pkg::cgc_ctl_s ctl_i,
    output cgc_pkg::cgc_evt_s      evt_o,
    output logic                   tx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import cgc_pkg::*;
    int t = 0;  // frame position, 0 while the bus idles
    // fixed-length frame; overload slot after the frame end
    always @(posedge clk_i) begin
        t <= ((t != 0 && t < 20) || go_i) ? t + 1 : 0;
    end
    // events decoded from position; tx bit toggles so stale values show
    always_comb begin
        evt_o.frame_active = t inside {[1:13]};
        evt_o.sof          = t == 1;
        evt_o.eof_last     = t == 13;
        evt_o.rx_msg_done  = t == 13;
        evt_o.ovl_start    = t == 16 && ctl_i.ovl_pending;
        evt_o.ovl_active   = t inside {[16:19]} && ctl_i.ovl_pending;
        tx_o               = t inside {[1:12]} ? t[0] : 1'b1;
    end
endmodule

// File: testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cgc_pkg::*;
    logic       clk_i = 0, rst_i = 1, wb_we_i = 0, wb_sel_i = 0, wb_cyc_i = 0, wb_stb_i = 0, go = 0;
    logic [7:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, q;
    logic       wb_ack_o, tx_engine_i, can_tx_o;
    cgc_evt_s   evt_i;
    cgc_ctl_s   ctl_o;
    int         miscompares = 0, cmp_count = 0, cycles = 0, caps = 0, cap_at = 0, go_at, c0, d;
    cgc_global_control uut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i,
        .wb_stb_i, .wb_dat_o, .wb_ack_o, .evt_i, .tx_engine_i, .ctl_o, .can_tx_o);
    cgc_can_node node (.clk_i, .go_i(go), .ctl_i(ctl_o), .evt_o(evt_i), .tx_o(tx_engine_i));
    always #25 clk_i = ~clk_i;
    // cycle count, capture log and hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (ctl_o.timer_capture === 1'b1) begin
            caps <= caps + 1;
            cap_at <= cycles;
        end
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done();
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; waits for ack however long it takes
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] dt);
        {wb_adr_i, wb_we_i, wb_dat_i, wb_sel_i, wb_cyc_i, wb_stb_i} <= {a, w, dt, 3'b111};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wb(a, 1'b0, 8'h00);
        cmp(q, exp);
    endtask
    task automatic kick();
        go <= 1'b1;
        go_at = cycles;
        @(posedge clk_i);
        go <= 1'b0;
    endtask
    initial begin
        void'($urandom(93));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CGC_ADDR_CONTROL, CGC_CONTROL_RESET);
        rd(CGC_ADDR_STATUS, 8'h00);
        wb(8'h08, 1'b1, 8'hff);
        rd(8'h08, 8'h00);
        // random control words, factory test bit left clear
        for (int i = 0; i < 8; i++) begin
            d = $urandom & 8'h7b;
            wb(CGC_ADDR_CONTROL, 1'b1, d[7:0]);
            rd(CGC_ADDR_CONTROL, d[0] ? 8'h00 : d[7:0]);
        end
        // every tt mode / sync select pairing over one frame
        for (int m = 0; m < 4; m++) begin
            wb(CGC_ADDR_CONTROL, 1'b1, 8'h02 | (m << 4));
            repeat (3) @(posedge clk_i);
            rd(CGC_ADDR_STATUS, 8'h04);
            cmp({ctl_o.engine_run, ctl_o.clk_gate_en, ctl_o.rx_enable, ctl_o.tt_mode}, {3'b111, m[1]});
            c0 = caps;
            kick();
            repeat (22) @(posedge clk_i);
            cmp(caps - c0, m[1]);
            if (m[1]) cmp(cap_at - go_at, m[0] ? 15 : 3);
        end
        // overload armed by a received message, then cleared by hardware
        wb(CGC_ADDR_CONTROL, 1'b1, 8'h42);
        kick();
        repeat (22) @(posedge clk_i);
        rd(CGC_ADDR_CONTROL, 8'h02);
        // disable mid-frame: still enabled until the frame ends
        kick();
        wb(CGC_ADDR_CONTROL, 1'b1, 8'h00);
        rd(CGC_ADDR_STATUS, 8'h04);
        repeat (20) @(posedge clk_i);
        rd(CGC_ADDR_STATUS, 8'h00);
        cmp({ctl_o.engine_run, ctl_o.clk_gate_en, ctl_o.rx_enable, can_tx_o}, 4'b0001);
        // hardware reset during the enable start-up delay
        wb(CGC_ADDR_CONTROL, 1'b1, 8'h3a);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CGC_ADDR_CONTROL, 8'h00);
        test_done();
    end
endmodule
